// ---- core/rlp_cfg.svh ----
// constants for the raise/lower ramp potentiometer
// assumes a 100 MHz system clock and hundredths-of-percent values
`ifndef RLP_CFG_SVH
`define RLP_CFG_SVH
`define RLP_VAL_W        16
`define RLP_TIME_W       13
`define RLP_PCT_MAX      16'sd30000
`define RLP_PCT_MIN      -16'sd30000
`define RLP_PRELOAD_RST  16'sd0
`define RLP_FLOOR_RST    -16'sd10000
`define RLP_CEIL_RST     16'sd10000
`define RLP_TIME_RST     13'd100
`define RLP_TIME_MIN     13'd1
`define RLP_TIME_MAX     13'd6000
`define RLP_FULL_SCALE   16'd10000
`define RLP_CLK_MHZ      100
`define RLP_TENTH_S_NS   100000000
`define RLP_CLK_NS       10
`endif

// ---- core/rlp_pkg.sv ----
// types for the raise/lower ramp potentiometer
// assumes nothing beyond the cfg header
package rlp_pkg;
  typedef logic signed [15:0] rlp_val_t;
  typedef enum logic [1:0]
  {
    RLP_HOLD  = 2'b00,
    RLP_UP    = 2'b01,
    RLP_DOWN  = 2'b10,
    RLP_LOAD  = 2'b11
  } rlp_mode_e;
endpackage : rlp_pkg

// ---- core/rlp_tick.sv ----
// step tick generator: one pulse per hundredth-percent step
// assumes slew time in tenths of a second, held steady while used
`timescale 1ns/1ps
`include "rlp_cfg.svh"
module rlp_tick #(
  parameter int TENTH_CYC = `RLP_TENTH_S_NS / `RLP_CLK_NS / `RLP_FULL_SCALE
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     run,
  input  wire logic [`RLP_TIME_W-1:0]   slew_time,
  output logic                          tick
);
  if (TENTH_CYC < 1 || TENTH_CYC > 700000)
  begin : g_bad_tenth
    $error("rlp_tick: TENTH_CYC out of range");
  end

  localparam int CW = 32;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] limit;

  // cycles per step = time * tenth-second cycles / full-scale steps
  always_comb
  begin
    limit = CW'(TENTH_CYC) * CW'(slew_time);
    if (limit == '0)
    begin
      limit = CW'(1);
    end
    cnt_d = cnt_q;
    tick  = 1'b0;
    if (!run)
    begin
      cnt_d = '0;
    end
    else if (cnt_q + CW'(1) >= limit)
    begin
      cnt_d = '0;
      tick  = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end
endmodule : rlp_tick

// ---- core/rlp_core.sv ----
// raise/lower ramp potentiometer: slews a signed percent output
// assumes all inputs synchronous to sys_clk; values in 0.01 percent
// Functional notes
// - preload request and power-up load the clamped preload level into the output
// - output is not retained; every reset restarts from the preload level
// - up slew time applies when the output moves away from zero
// - down slew time applies when the output moves towards zero
// - up request alone raises output at rate, never above ceiling
// - down request alone lowers output at rate, never below floor
// - with no request the output holds its last value
// - both requests together hold the output
// - floor above ceiling forces the output to zero
// - floor is an immediate clamp; limits span plus minus 300.00 percent
// - preload level defaults to 0.00 percent
`timescale 1ns/1ps
`include "rlp_cfg.svh"
module rlp_core #(
  parameter int TENTH_CYC = `RLP_TENTH_S_NS / `RLP_CLK_NS / `RLP_FULL_SCALE
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     up_req,
  input  wire logic                     down_req,
  input  wire logic                     preload_req,
  input  wire logic signed [15:0]       preload_level,
  input  wire logic signed [15:0]       floor_clamp,
  input  wire logic signed [15:0]       ceil_clamp,
  input  wire logic [`RLP_TIME_W-1:0]   up_slew_time,
  input  wire logic [`RLP_TIME_W-1:0]   down_slew_time,
  output logic signed [15:0]            pot_out,
  output logic                          ramping
);
  if (TENTH_CYC < 1 || TENTH_CYC > 700000)
  begin : g_bad_tenth
    $error("rlp_core: TENTH_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // limit conditioning
  rlp_pkg::rlp_val_t    flo;
  rlp_pkg::rlp_val_t    cei;
  rlp_pkg::rlp_val_t    pre;
  rlp_pkg::rlp_val_t    pre_cl;
  logic                 inverted;

  function automatic rlp_pkg::rlp_val_t sat(input rlp_pkg::rlp_val_t v);
    if (v > `RLP_PCT_MAX)
    begin
      return `RLP_PCT_MAX;
    end
    else if (v < `RLP_PCT_MIN)
    begin
      return `RLP_PCT_MIN;
    end
    return v;
  endfunction : sat

  always_comb
  begin
    flo      = sat(floor_clamp);
    cei      = sat(ceil_clamp);
    pre      = sat(preload_level);
    inverted = flo > cei;
    pre_cl   = pre;
    if (pre_cl > cei)
    begin
      pre_cl = cei;
    end
    if (pre_cl < flo)
    begin
      pre_cl = flo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode and slew selection
  rlp_pkg::rlp_mode_e   mode;
  logic                 away;
  logic [`RLP_TIME_W-1:0] sel_time;
  logic [`RLP_TIME_W-1:0] sel_clip;
  logic                 tick;
  logic                 run;
  logic                 init_q;
  logic                 init_d;

  always_comb
  begin
    if (preload_req || init_q)
    begin
      mode = rlp_pkg::RLP_LOAD;
    end
    else if (up_req && !down_req)
    begin
      mode = rlp_pkg::RLP_UP;
    end
    else if (down_req && !up_req)
    begin
      mode = rlp_pkg::RLP_DOWN;
    end
    else
    begin
      mode = rlp_pkg::RLP_HOLD;
    end
    // moving away from zero: up from non-negative or down from non-positive
    away = (mode == rlp_pkg::RLP_UP) ? (pot_out >= 0) : (pot_out <= 0);
    sel_time = away ? up_slew_time : down_slew_time;
    sel_clip = sel_time;
    if (sel_clip < `RLP_TIME_MIN)
    begin
      sel_clip = `RLP_TIME_MIN;
    end
    if (sel_clip > `RLP_TIME_MAX)
    begin
      sel_clip = `RLP_TIME_MAX;
    end
    run = !inverted && ((mode == rlp_pkg::RLP_UP && pot_out < cei)
                     || (mode == rlp_pkg::RLP_DOWN && pot_out > flo));
  end

  rlp_tick #(
    .TENTH_CYC (TENTH_CYC)
  ) u_tick (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .run       (run),
    .slew_time (sel_clip),
    .tick      (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output register
  rlp_pkg::rlp_val_t    out_d;
  logic                 ramping_d;

  always_comb
  begin
    out_d     = pot_out;
    init_d    = 1'b0;
    ramping_d = 1'b0;
    if (inverted)
    begin
      out_d = '0;
    end
    else
    begin
      unique case (mode)
        rlp_pkg::RLP_LOAD:
        begin
          out_d = pre_cl;
        end
        rlp_pkg::RLP_UP:
        begin
          ramping_d = run;
          if (tick)
          begin
            out_d = pot_out + 16'sd1;
          end
        end
        rlp_pkg::RLP_DOWN:
        begin
          ramping_d = run;
          if (tick)
          begin
            out_d = pot_out - 16'sd1;
          end
        end
        rlp_pkg::RLP_HOLD:
        begin
          out_d = pot_out;
        end
      endcase
      if (out_d > cei)
      begin
        out_d = cei;
      end
      if (out_d < flo)
      begin
        out_d = flo;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pot_out <= `RLP_PRELOAD_RST;
      init_q  <= 1'b1;
      ramping <= 1'b0;
    end
    else
    begin
      pot_out <= out_d;
      init_q  <= init_d;
      ramping <= ramping_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_load;
    preload_req && !inverted;
  endsequence

  sequence s_load_contested;
    preload_req && !inverted && (up_req || down_req);
  endsequence

  sequence s_load_held;
    preload_req && !inverted && (up_req || down_req) && $stable(pre_cl);
  endsequence

  sequence s_raise_tick;
    tick && mode == rlp_pkg::RLP_UP && !inverted && pot_out >= flo;
  endsequence

  sequence s_lower_tick;
    tick && mode == rlp_pkg::RLP_DOWN && !inverted && pot_out <= cei;
  endsequence

  a_reset_value: assert property (@(posedge sys_clk)
    !rst_n |=> pot_out == 16'sh0000 && init_q && !ramping)
    else $error("reset did not clear the output");

  a_power_up_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (init_q && !inverted) |=> pot_out == $past(pre_cl))
    else $error("power-up did not load the preload level");

  a_preload_loads: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_load |=> (pot_out == $past(pre_cl)))
    else $error("preload level not loaded");

  a_inverted_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    inverted |=> (pot_out == 0) || !$past(inverted))
    else $error("output not zero with floor above ceiling");

  a_inverted_preload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (inverted && (preload_req || init_q)) |=> pot_out == 16'sh0000)
    else $error("preload overrode the inverted limits");

  a_preload_priority: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_load_contested ##1 s_load_held |=> $stable(pot_out))
    else $error("request moved the output during preload");

  a_hold_both: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (up_req && down_req && !preload_req && !init_q && !inverted
     && pot_out <= cei && pot_out >= flo) |=> $stable(pot_out))
    else $error("output moved while both requests held");

  a_hold_none: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!up_req && !down_req && !preload_req && !init_q && !inverted
     && pot_out <= cei && pot_out >= flo) |=> $stable(pot_out))
    else $error("output moved with no request");

  a_ceil_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (up_req && !down_req && !preload_req && !init_q && !inverted && $stable(cei) && pot_out <= cei)
    |=> pot_out <= $past(cei) && pot_out >= $past(pot_out))
    else $error("raise passed ceiling or fell");

  a_floor_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (down_req && !up_req && !preload_req && !init_q && !inverted && $stable(flo) && pot_out >= flo)
    |=> pot_out >= $past(flo) && pot_out <= $past(pot_out))
    else $error("lower passed floor or rose");

  a_step_unit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_raise_tick |=> pot_out - $past(pot_out) == 1)
    else $error("raise step not one count");

  a_step_lower: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_lower_tick |=> $past(pot_out) - pot_out == 1)
    else $error("lower step not one count");

  a_rate_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == rlp_pkg::RLP_UP && pot_out > 0) |-> sel_time == up_slew_time)
    else $error("wrong slew time moving away from zero");

  a_rate_toward: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == rlp_pkg::RLP_DOWN && pot_out > 0) |-> sel_time == down_slew_time)
    else $error("wrong slew time moving towards zero");

  a_rate_away_neg: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == rlp_pkg::RLP_DOWN && pot_out < 16'sh0000) |-> sel_time == up_slew_time)
    else $error("wrong slew time lowering below zero");

  a_rate_toward_neg: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == rlp_pkg::RLP_UP && pot_out < 16'sh0000) |-> sel_time == down_slew_time)
    else $error("wrong slew time raising below zero");

  a_rate_at_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode inside {rlp_pkg::RLP_UP, rlp_pkg::RLP_DOWN} && pot_out == 16'sh0000) |-> sel_time == up_slew_time)
    else $error("wrong slew time leaving zero");

  a_floor_clamp: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($past(rst_n) && !$past(inverted)) |-> pot_out >= $past(flo) && pot_out <= $past(cei))
    else $error("output outside floor or ceiling");

  a_ramping_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((up_req == down_req) || preload_req || inverted) |=> !ramping)
    else $error("ramping flag set without a single request");

  a_ramping_active: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (up_req && !down_req && !preload_req && !init_q && !inverted && pot_out < cei)
    |=> ramping)
    else $error("ramping flag low while raising");

  a_ramping_at_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (up_req && !down_req && !preload_req && !init_q && pot_out >= cei)
    |=> !ramping)
    else $error("ramping flag high at ceiling");
endmodule : rlp_core

// ---- tb/raise_lower_ramp_potentiometer_tb.sv ----
// self-checking bench for the raise/lower ramp potentiometer core
// assumes rlp_core with TENTH_CYC=1, inputs driven at the falling edge
`timescale 1ns/1ps
`include "rlp_cfg.svh"
module raise_lower_ramp_potentiometer_tb;
  logic                       sys_clk;
  logic                       rst_n;
  logic                       up_req;
  logic                       down_req;
  logic                       preload_req;
  logic signed [15:0]         preload_level;
  logic signed [15:0]         floor_clamp;
  logic signed [15:0]         ceil_clamp;
  logic [`RLP_TIME_W-1:0]     up_slew_time;
  logic [`RLP_TIME_W-1:0]     down_slew_time;
  logic signed [15:0]         pot_out;
  logic                       ramping;
  logic signed [16:0]         delta;
  logic [31:0]                rng_q;
  int                         mismatches;
  int                         num_checks;
  int                         cycles;
  int                         n;
  logic                       b;

  rlp_core #(.TENTH_CYC(1)) u_rlp_core (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .up_req         (up_req),
    .down_req       (down_req),
    .preload_req    (preload_req),
    .preload_level  (preload_level),
    .floor_clamp    (floor_clamp),
    .ceil_clamp     (ceil_clamp),
    .up_slew_time   (up_slew_time),
    .down_slew_time (down_slew_time),
    .pot_out        (pot_out),
    .ramping        (ramping)
  );

  ////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift

  function automatic logic signed [15:0] exp_clamp(input logic signed [15:0] v, input logic signed [15:0] f,
                                                   input logic signed [15:0] c);
    if (f > c) return 16'sh0000;
    if (v < f) return f;
    if (v > c) return c;
    return v;
  endfunction : exp_clamp

  task automatic next_pct(output logic signed [15:0] v);
    rng_q = xorshift(rng_q);
    v = 16'(int'(rng_q % 32'd60001) - 30000);
  endtask : next_pct

  task automatic step(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : step

  task automatic check(input string what, input logic signed [15:0] exp, input logic signed [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  task automatic check_rng(input string what, input int lo, input int hi, input logic signed [16:0] got);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      mismatches++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_rng

  // hold a request pattern for k cycles, release, report the change
  task automatic ramp(input logic u, input logic d, input int k, output logic signed [16:0] dl);
    logic signed [15:0] s;
    s = pot_out;
    up_req = u;
    down_req = d;
    step(k);
    up_req = 1'b0;
    down_req = 1'b0;
    step(3);
    dl = pot_out - s;
  endtask : ramp

  task automatic preload(input logic signed [15:0] v);
    preload_level = v;
    preload_req = 1'b1;
    step(2);
    preload_req = 1'b0;
  endtask : preload

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////
  initial
  begin
    rng_q = 32'h0000_0038;
    rst_n = 1'b0;
    up_req = 1'b0;
    down_req = 1'b0;
    preload_req = 1'b0;
    preload_level = 16'sh01F4;
    floor_clamp = 16'shD8F0;
    ceil_clamp = 16'sh2710;
    up_slew_time = 13'h0004;
    down_slew_time = 13'h0002;
    step(4);
    check("pot_out in reset", 16'sh0000, pot_out);
    rst_n = 1'b1;
    step(2);
    check("pot_out after power-up", 16'sh01F4, pot_out);
    ramp(1'b1, 1'b0, 400, delta);
    check_rng("up away from zero", 98, 101, delta);
    ramp(1'b0, 1'b1, 200, delta);
    check_rng("down towards zero", -101, -98, delta);
    preload(16'shFE0C);
    check("pot_out preload", 16'shFE0C, pot_out);
    ramp(1'b0, 1'b1, 400, delta);
    check_rng("down away from zero", -101, -98, delta);
    ramp(1'b1, 1'b0, 200, delta);
    check_rng("up towards zero", 98, 101, delta);
    up_slew_time = 13'h0001;
    down_slew_time = 13'h0001;
    ceil_clamp = 16'sh0258;
    floor_clamp = 16'shFDA8;
    ramp(1'b1, 1'b0, 1300, delta);
    check("pot_out at ceiling", 16'sh0258, pot_out);
    ramp(1'b0, 1'b1, 1300, delta);
    check("pot_out at floor", 16'shFDA8, pot_out);
    floor_clamp = 16'sh0064;
    step(2);
    check("pot_out floor raised", 16'sh0064, pot_out);
    up_req = 1'b1;
    step(2);
    check("ramping while raising", 16'sh0001, 16'(ramping));
    step(600);
    check("ramping at ceiling", 16'sh0000, 16'(ramping));
    check("pot_out ceiling again", 16'sh0258, pot_out);
    up_req = 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      rng_q = xorshift(rng_q);
      b = rng_q[0];
      n = int'(rng_q[13:8]) + 1;
      ramp(b, b, n, delta);
      check_rng("hold change", 0, 0, delta);
    end
    ceil_clamp = 16'sh0032;
    step(2);
    check("pot_out inverted limits", 16'sh0000, pot_out);
    up_req = 1'b1;
    preload(16'sh0040);
    up_req = 1'b0;
    check("pot_out inverted with preload", 16'sh0000, pot_out);
    ceil_clamp = 16'sh2710;
    floor_clamp = 16'shD8F0;
    for (int i = 0; i < 24; i++)
    begin
      next_pct(preload_level);
      next_pct(floor_clamp);
      next_pct(ceil_clamp);
      rng_q = xorshift(rng_q);
      up_req = rng_q[0];
      down_req = rng_q[1];
      preload_req = 1'b1;
      step(2);
      check("pot_out clamped preload", exp_clamp(preload_level, floor_clamp, ceil_clamp), pot_out);
      step(20);
      check("pot_out preload priority", exp_clamp(preload_level, floor_clamp, ceil_clamp), pot_out);
      preload_req = 1'b0;
      up_req = 1'b0;
      down_req = 1'b0;
    end
    floor_clamp = 16'shD8F0;
    ceil_clamp = 16'sh2710;
    preload(16'sh0100);
    ramp(1'b1, 1'b0, 30, delta);
    preload(16'sh0000);
    check("pot_out default preload", 16'sh0000, pot_out);
    preload_level = 16'sh0123;
    ramp(1'b1, 1'b0, 30, delta);
    rst_n = 1'b0;
    step(2);
    check("pot_out mid-run reset", 16'sh0000, pot_out);
    rst_n = 1'b1;
    step(2);
    check("pot_out restart from preload", 16'sh0123, pot_out);
    test_done();
  end
endmodule : raise_lower_ramp_potentiometer_tb
